/* File: verilog/rifc_ref_input_frame_alignment_config.sv */
// Reference input and frame alignment configuration bank with an AXI4-Lite slave.
// Assumes monitor valid flags, sync pulses and the sync pin arrive asynchronously.
// Contract
// - One power-down bit per receiver, fourth at bit 3, all clear at reset.
// - All four power-down bits set puts the receiver section into deep sleep.
// - Two-bit family per reference, 00 differential, others CMOS voltage ranges.
// - A CMOS family reference uses only its positive leg, complement ignored.
// - Two-bit switchover priority per reference, level 0 to 3, reset 0.
// - Frame alignment enabled only while enable bit 0 is one; off at reset.
// - Validation gate set: first reference valid only if second also valid.
// - Validation gate set: third reference valid only if fourth also valid.
// - Validation gate clear: only the selected reference's own validity counts.
// - Settings bit 2 chooses one-shot or level-sensitive frame alignment.
// - Level mode aligns on every pulse edge; one-shot only first after arming.
// - Settings bit 1 picks arming source: sync pin or software arm bit.
// - Software arm bit arms after update; next sync pulse is the event.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module rifc_ref_input_frame_alignment_config
  import rifc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [RIFC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RIFC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] ref_valid_raw,
  input wire logic [1:0] ref_selected,
  input wire logic sync_pulse_second,
  input wire logic sync_pulse_fourth,
  input wire logic sync_pin_n,
  output logic [3:0] rx_powerdown,
  output logic rx_deep_sleep,
  output logic [7:0] rx_family,
  output logic [3:0] rx_negative_leg_enable,
  output logic [7:0] ref_priority,
  output logic [3:0] ref_valid_qualified,
  output logic selected_valid,
  output logic frame_align_enabled,
  output logic frame_align_armed,
  output logic frame_align_event
);

  // Shadow registers written by software and active copies loaded on update
  logic [3:0] pd_sh_q;
  logic [7:0] fam_sh_q;
  logic [7:0] pri_sh_q;
  logic en_sh_q;
  logic [3:0] set_sh_q;
  logic [3:0] pd_act_q;
  logic [7:0] fam_act_q;
  logic [7:0] pri_act_q;
  logic en_act_q;
  logic [3:0] set_act_q;
  logic update_q;

  // Write channel holding state
  logic aw_held_q;
  logic w_held_q;
  logic [RIFC_IDX_W-1:0] aw_idx_q;
  logic [7:0] w_byte_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Synchronised pin-class inputs
  logic [3:0] valid_s;
  logic pulse2_s;
  logic pulse4_s;
  logic sync_pin_n_s;
  logic pulse_prev_q;
  logic pin_prev_n_q;
  logic armed_q;
  logic event_q;

  // Monitor flags cross into aclk before the gate reads them
  rifc_pin_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_valid_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ref_valid_raw),
    .level_out(valid_s)
  );

  // Sync pulses and the arming pin come from outside the clock domain
  rifc_pin_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_pulse_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({sync_pin_n, sync_pulse_fourth, sync_pulse_second}),
    .level_out({sync_pin_n_s, pulse4_s, pulse2_s})
  );

  // Write handshake: address and data taken in either order, response after both
  logic aw_take;
  logic w_take;
  logic do_write;
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write decode on the held index; only byte lane 0 carries register bits
  logic wr_pd;
  logic wr_fam;
  logic wr_pri;
  logic wr_en;
  logic wr_set;
  logic wr_upd;
  logic wr_stat;
  logic wr_hit;
  assign wr_pd = do_write & (aw_idx_q == RIFC_IDX_POWERDOWN);
  assign wr_fam = do_write & (aw_idx_q == RIFC_IDX_FAMILY);
  assign wr_pri = do_write & (aw_idx_q == RIFC_IDX_PRIORITY);
  assign wr_en = do_write & (aw_idx_q == RIFC_IDX_FA_ENABLE);
  assign wr_set = do_write & (aw_idx_q == RIFC_IDX_FA_SETTINGS);
  assign wr_upd = do_write & (aw_idx_q == RIFC_IDX_UPDATE);
  assign wr_stat = do_write & (aw_idx_q == RIFC_IDX_STATUS);
  assign wr_hit = wr_pd | wr_fam | wr_pri | wr_en | wr_set | wr_upd | wr_stat;

  // Capture address and data as each arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 12'h000;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[RIFC_ADDR_W-1:2];
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped indices answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RIFC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RIFC_RESP_OKAY : RIFC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Shadow registers; reserved bits are never stored
  logic lane_ok;
  assign lane_ok = w_lane0_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_sh_q <= RIFC_RST_POWERDOWN;
      fam_sh_q <= RIFC_RST_FAMILY;
      pri_sh_q <= RIFC_RST_PRIORITY;
      en_sh_q <= RIFC_RST_FA_ENABLE;
      set_sh_q <= RIFC_RST_FA_SETTINGS;
    end else if (lane_ok) begin
      if (wr_pd) begin
        pd_sh_q <= w_byte_q[3:0];
      end
      if (wr_fam) begin
        fam_sh_q <= w_byte_q;
      end
      if (wr_pri) begin
        pri_sh_q <= w_byte_q;
      end
      if (wr_en) begin
        en_sh_q <= w_byte_q[RIFC_FA_ENABLE_BIT];
      end
      if (wr_set) begin
        set_sh_q <= w_byte_q[3:0];
      end
    end
  end

  // Update strobe is self-clearing; it pulses one cycle after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update_q <= 1'b0;
    end else begin
      update_q <= wr_upd & lane_ok & w_byte_q[RIFC_UPDATE_BIT];
    end
  end

  // Active copies steer the hardware; shadows change nothing until update, except shadow settings bit 1, whose set value picks software arming at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_act_q <= RIFC_RST_POWERDOWN;
      fam_act_q <= RIFC_RST_FAMILY;
      pri_act_q <= RIFC_RST_PRIORITY;
      en_act_q <= RIFC_RST_FA_ENABLE;
      set_act_q <= RIFC_RST_FA_SETTINGS;
    end else if (update_q) begin
      pd_act_q <= pd_sh_q;
      fam_act_q <= fam_sh_q;
      pri_act_q <= pri_sh_q;
      en_act_q <= en_sh_q;
      set_act_q <= set_sh_q;
    end
  end

  // Receiver controls from the active copies
  assign rx_powerdown = pd_act_q;
  assign rx_deep_sleep = &pd_act_q;
  assign rx_family = fam_act_q;
  assign ref_priority = pri_act_q;

  // Complement leg is dropped whenever a CMOS family is selected
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_leg
      assign rx_negative_leg_enable[gi] = (fam_act_q[2*gi+1:2*gi] == RIFC_FAMILY_DIFF);
    end
  endgenerate

  // Validation gate pairs each main reference with its sync-pulse partner
  logic gate_on;
  assign gate_on = set_act_q[RIFC_SET_VALIDATE];
  assign ref_valid_qualified[0] = valid_s[0] & (~gate_on | valid_s[1]);
  assign ref_valid_qualified[1] = valid_s[1];
  assign ref_valid_qualified[2] = valid_s[2] & (~gate_on | valid_s[3]);
  assign ref_valid_qualified[3] = valid_s[3];
  assign selected_valid = ref_valid_qualified[ref_selected];

  // Sync pulse comes from the partner of the selected pair
  logic pulse_now;
  logic pulse_edge;
  logic one_shot;
  logic use_soft;
  logic pin_release;
  logic soft_rise;
  logic arm_set;
  logic event_hit;
  assign pulse_now = ref_selected[1] ? pulse4_s : pulse2_s;
  assign pulse_edge = pulse_now & ~pulse_prev_q;
  assign one_shot = set_act_q[RIFC_SET_ONE_SHOT];
  assign use_soft = set_sh_q[RIFC_SET_ARM_SRC];
  // Pin arming needs a high then low; the edge back to low arms
  assign pin_release = ~sync_pin_n_s & pin_prev_n_q;
  // Software arming needs the arm bit to go from clear to set across updates
  assign soft_rise = update_q & set_sh_q[RIFC_SET_SOFT_ARM] & ~set_act_q[RIFC_SET_SOFT_ARM];
  assign arm_set = use_soft ? soft_rise : (~set_act_q[RIFC_SET_ARM_SRC] & pin_release);
  // Level mode fires on every edge; one-shot needs an armed state
  assign event_hit = en_act_q & pulse_edge & (~one_shot | armed_q);

  // Edge history for the pulse and pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_prev_q <= 1'b0;
      pin_prev_n_q <= 1'b1;
    end else begin
      pulse_prev_q <= pulse_now;
      pin_prev_n_q <= sync_pin_n_s;
    end
  end

  // Armed flag: a new arm in the same cycle as a consumed pulse wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (arm_set) begin
      armed_q <= 1'b1;
    end else if (event_hit & one_shot) begin
      armed_q <= 1'b0;
    end
  end

  // One-cycle alignment event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_hit;
    end
  end

  assign frame_align_enabled = en_act_q;
  assign frame_align_armed = armed_q;
  assign frame_align_event = event_q;

  // Read decode; status shows live state of the block
  logic ar_take;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [RIFC_IDX_W-1:0] ar_idx;
  logic [31:0] status_word;
  assign s_axi_arready = ~rvalid_q;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[RIFC_ADDR_W-1:2];
  assign status_word = {25'h0000000, rx_deep_sleep, armed_q, ref_valid_qualified,
                        selected_valid};
  assign rd_hit = (ar_idx == RIFC_IDX_POWERDOWN) | (ar_idx == RIFC_IDX_FAMILY)
                | (ar_idx == RIFC_IDX_PRIORITY) | (ar_idx == RIFC_IDX_FA_ENABLE)
                | (ar_idx == RIFC_IDX_FA_SETTINGS) | (ar_idx == RIFC_IDX_UPDATE)
                | (ar_idx == RIFC_IDX_STATUS);
  // Reserved bits and the update register read as zero
  assign rd_word = (ar_idx == RIFC_IDX_POWERDOWN) ? {28'h0000000, pd_sh_q} :
                   (ar_idx == RIFC_IDX_FAMILY) ? {24'h000000, fam_sh_q} :
                   (ar_idx == RIFC_IDX_PRIORITY) ? {24'h000000, pri_sh_q} :
                   (ar_idx == RIFC_IDX_FA_ENABLE) ? {31'h00000000, en_sh_q} :
                   (ar_idx == RIFC_IDX_FA_SETTINGS) ? {28'h0000000, set_sh_q} :
                   (ar_idx == RIFC_IDX_STATUS) ? status_word :
                   32'h00000000;

  // Read data is registered and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RIFC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RIFC_RESP_OKAY : RIFC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

/* File: verilog/rifc_pkg.sv */
// Constants shared by the reference input and frame alignment configuration bank.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register index.
package rifc_pkg;

  // Bus geometry: byte address is four times the register index
  localparam int RIFC_ADDR_W = 14;
  localparam int RIFC_IDX_W = 12;

  // Register indices
  localparam logic [11:0] RIFC_IDX_UPDATE = 12'h005;
  localparam logic [11:0] RIFC_IDX_POWERDOWN = 12'h600;
  localparam logic [11:0] RIFC_IDX_FAMILY = 12'h601;
  localparam logic [11:0] RIFC_IDX_PRIORITY = 12'h602;
  localparam logic [11:0] RIFC_IDX_FA_ENABLE = 12'h640;
  localparam logic [11:0] RIFC_IDX_FA_SETTINGS = 12'h641;
  localparam logic [11:0] RIFC_IDX_STATUS = 12'h6F0;

  // Reset values
  localparam logic [3:0] RIFC_RST_POWERDOWN = 4'h0;
  localparam logic [7:0] RIFC_RST_FAMILY = 8'h00;
  localparam logic [7:0] RIFC_RST_PRIORITY = 8'h00;
  localparam logic RIFC_RST_FA_ENABLE = 1'b0;
  localparam logic [3:0] RIFC_RST_FA_SETTINGS = 4'h0;

  // Field positions
  localparam int RIFC_UPDATE_BIT = 0;
  localparam int RIFC_FA_ENABLE_BIT = 0;
  localparam int RIFC_SET_SOFT_ARM = 0;
  localparam int RIFC_SET_ARM_SRC = 1;
  localparam int RIFC_SET_ONE_SHOT = 2;
  localparam int RIFC_SET_VALIDATE = 3;
  localparam logic [1:0] RIFC_FAMILY_DIFF = 2'h0;

  // Status word fields
  localparam int RIFC_ST_SEL_VALID = 0;
  localparam int RIFC_ST_QUAL_LSB = 1;
  localparam int RIFC_ST_ARMED = 5;
  localparam int RIFC_ST_SLEEP = 6;

  // Bus responses
  localparam logic [1:0] RIFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RIFC_RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/rifc_pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin-level inputs.
// Assumes inputs are asynchronous to aclk; output moves only once stages two and three agree.
`timescale 1ns/1ps
module rifc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // Per bit, take the new value only where the later stages agree
  assign level_d = (stage2_q ~^ stage3_q) & stage3_q | ~(stage2_q ~^ stage3_q) & level_q;
  assign level_out = level_q;

  // Stage one feeds stage two only, keeping metastability away from logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end

endmodule

/* File: tb/rifc_properties.sv */
// Concurrent checks on the ports of the configuration bank.
// Assumes one clock, aclk, with synchronous active-low aresetn.
`timescale 1ns/1ps
module rifc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] ref_valid_raw,
  input wire logic [1:0] ref_selected,
  input wire logic [3:0] rx_powerdown,
  input wire logic rx_deep_sleep,
  input wire logic [7:0] rx_family,
  input wire logic [3:0] rx_negative_leg_enable,
  input wire logic [3:0] ref_valid_qualified,
  input wire logic selected_valid,
  input wire logic frame_align_enabled,
  input wire logic frame_align_armed,
  input wire logic frame_align_event
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Write response follows once both halves are taken
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");
  // Sleep only ever rises with every receiver powered down
  property p_deep_sleep;
    rx_deep_sleep == (&rx_powerdown);
  endproperty
  a_deep_sleep: assert property (p_deep_sleep) else $error("deep sleep mismatch");
  // Complement leg is only used by a differential receiver
  property p_neg_leg;
    rx_negative_leg_enable == {rx_family[7:6] == 2'h0, rx_family[5:4] == 2'h0,
      rx_family[3:2] == 2'h0, rx_family[1:0] == 2'h0};
  endproperty
  a_neg_leg: assert property (p_neg_leg) else $error("leg enable mismatch");
  property p_sel_valid;
    selected_valid == ref_valid_qualified[ref_selected];
  endproperty
  a_sel_valid: assert property (p_sel_valid) else $error("selected valid mismatch");
  // Synchronised flag lags the raw monitor flag by a few edges
  property p_valid_sync;
    (ref_valid_qualified & ~($past(ref_valid_raw, 3) | $past(ref_valid_raw, 4)
      | $past(ref_valid_raw, 5))) == 4'h0;
  endproperty
  a_valid_sync: assert property (p_valid_sync) else $error("valid without raw flag");
  property p_event_enabled;
    frame_align_event |-> $past(frame_align_enabled);
  endproperty
  a_event_enabled: assert property (p_event_enabled) else $error("event while off");
  // Armed state is spent only by an alignment event
  property p_arm_clear;
    $fell(frame_align_armed) |-> frame_align_event;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("armed cleared without event");
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
endmodule

bind rifc_ref_input_frame_alignment_config rifc_properties u_props (.*);

/* File: tb/testbench.sv */
// Self-checking bench for the reference input and frame alignment bank.
// Assumes the bank alone, 10 MHz aclk, registers reached over AXI4-Lite.
`timescale 1ns/1ps
module testbench;
  import rifc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_deep_sleep;
  logic selected_valid, sync_pulse_second, sync_pulse_fourth, sync_pin_n, frame_align_enabled;
  logic frame_align_armed, frame_align_event;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ref_valid_raw, rx_powerdown, rx_negative_leg_enable;
  logic [3:0] ref_valid_qualified;
  logic [1:0] s_axi_bresp, s_axi_rresp, ref_selected;
  logic [7:0] rx_family, ref_priority;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  localparam logic [11:0] IDX [5] = '{RIFC_IDX_POWERDOWN, RIFC_IDX_FAMILY, RIFC_IDX_PRIORITY,
    RIFC_IDX_FA_ENABLE, RIFC_IDX_FA_SETTINGS};
  localparam logic [31:0] MSK [5] = '{32'h0F, 32'hFF, 32'hFF, 32'h01, 32'h0F};

  rifc_ref_input_frame_alignment_config DUT (.*);

  // Free-running 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // Buffered values only reach the outputs a couple of edges after the strobe
  task automatic upd;
    wr(RIFC_IDX_UPDATE, 32'h1, RIFC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // One sync pulse on the chosen pin, events counted over the whole window
  task automatic pulse(input logic fourth, output int cnt);
    cnt = 0;
    for (int k = 0; k < 14; k++) begin
      @(posedge aclk);
      if (fourth) sync_pulse_fourth <= (k < 5);
      else sync_pulse_second <= (k < 5);
      #1;
      if (frame_align_event === 1'b1) cnt++;
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < 5; i++) rdchk(IDX[i], 32'h0, RIFC_RESP_OKAY);
    chk(rx_negative_leg_enable, 32'hF);
    chk(frame_align_enabled, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_regs;
    for (int i = 0; i < 5; i++) wr(IDX[i], 32'hFFFFFFFF, RIFC_RESP_OKAY);
    for (int i = 0; i < 5; i++) rdchk(IDX[i], MSK[i], RIFC_RESP_OKAY);
    chk(rx_powerdown, 32'h0);
    wr(12'h123, 32'hFF, RIFC_RESP_SLVERR);
    rdchk(12'h123, 32'h0, RIFC_RESP_SLVERR);
    upd();
    chk({rx_deep_sleep, rx_powerdown}, 32'h1F);
    chk({ref_priority, rx_family}, 32'hFFFF);
    chk({frame_align_enabled, rx_negative_leg_enable}, 32'h10);
    wr(RIFC_IDX_POWERDOWN, 32'h8, RIFC_RESP_OKAY);
    upd();
    chk({rx_deep_sleep, rx_powerdown}, 32'h08);
    $display("register access done");
  endtask

  task automatic t_family;
    for (int c = 0; c < 4; c++) begin
      wr(RIFC_IDX_FAMILY, 32'(c) << 6, RIFC_RESP_OKAY);
      upd();
      chk({rx_negative_leg_enable[3], rx_family[7:6]}, {c == 0, 2'(c)});
    end
    $display("family codes done");
  endtask

  // Only the first and third monitors report valid, so the gate must bite
  task automatic t_validate;
    @(posedge aclk);
    ref_valid_raw <= 4'h5;
    for (int g = 0; g < 2; g++) begin
      wr(RIFC_IDX_FA_SETTINGS, 32'(g) << 3, RIFC_RESP_OKAY);
      upd();
      repeat (8) @(posedge aclk);
      #1;
      chk(ref_valid_qualified, g ? 32'h0 : 32'h5);
      chk(selected_valid, g ? 32'h0 : 32'h1);
    end
    @(posedge aclk);
    ref_valid_raw <= 4'hF;
    repeat (8) @(posedge aclk);
    #1;
    chk({selected_valid, ref_valid_qualified}, 32'h1F);
    $display("validation gate done");
  endtask

  task automatic t_frame_alignment;
    wr(RIFC_IDX_FA_SETTINGS, 32'h0, RIFC_RESP_OKAY);
    wr(RIFC_IDX_FA_ENABLE, 32'h1, RIFC_RESP_OKAY);
    upd();
    pulse(1'b0, n);
    chk(n, 32'h1);
    @(posedge aclk);
    ref_selected <= 2'h2;
    pulse(1'b1, n);
    chk(n, 32'h1);
    wr(RIFC_IDX_FA_ENABLE, 32'h0, RIFC_RESP_OKAY);
    upd();
    pulse(1'b1, n);
    chk(n, 32'h0);
    wr(RIFC_IDX_FA_ENABLE, 32'h1, RIFC_RESP_OKAY);
    wr(RIFC_IDX_FA_SETTINGS, 32'h6, RIFC_RESP_OKAY);
    upd();
    // The soft arm left over from the register test is spent by this first pulse
    pulse(1'b1, n);
    chk({frame_align_armed, 4'(n)}, 32'h1);
    wr(RIFC_IDX_FA_SETTINGS, 32'h7, RIFC_RESP_OKAY);
    upd();
    chk(frame_align_armed, 32'h1);
    pulse(1'b1, n);
    chk(n, 32'h1);
    pulse(1'b1, n);
    chk({frame_align_armed, 4'(n)}, 32'h0);
    wr(RIFC_IDX_FA_SETTINGS, 32'h4, RIFC_RESP_OKAY);
    upd();
    @(posedge aclk);
    sync_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    #1;
    chk(frame_align_armed, 32'h1);
    @(posedge aclk);
    sync_pin_n <= 1'b1;
    pulse(1'b1, n);
    chk({frame_align_armed, 4'(n)}, 32'h1);
    // Status: no sleep, disarmed, all four qualified, third reference selected and valid
    rdchk(RIFC_IDX_STATUS, 32'h1F, RIFC_RESP_OKAY);
    $display("frame alignment done");
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    results();
  end

  // Reset held five cycles, then the scenarios in order
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ref_valid_raw, ref_selected} = '0;
    {s_axi_awprot, s_axi_arprot, sync_pulse_second, sync_pulse_fourth} = '0;
    s_axi_wstrb = 4'hF;
    sync_pin_n = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_family();
    t_validate();
    t_frame_alignment();
    results();
  end
endmodule
